// >>> src/ddrms_map.svh
// Constants of the operating setting and its command decode
`ifndef DDRMS_MAP_SVH
`define DDRMS_MAP_SVH
// ============================================================
// Field positions of the operating setting
`define OPS_WIDTH      13
`define OPS_RESET      13'h0032
`define OPS_BC_LSB     0
`define OPS_BC_MSB     2
`define OPS_BT_BIT     3
`define OPS_RLS_LSB    4
`define OPS_RLS_MSB    6
`define OPS_TM_BIT     7
`define OPS_DLL_BIT    8
`define OPS_WR_LSB     9
`define OPS_WR_MSB     11
`define OPS_PDX_BIT    12
// ============================================================
// Field codes
`define BC_CODE4       3'h2
`define BC_CODE8       3'h3
`define RLS_CODE_MIN   3'h3
`define WR_CODE_OFFSET 4'h1
`define LAST_BEAT4     3'h3
`define LAST_BEAT8     3'h7
// ============================================================
// Pins and commands ({ras_n, cas_n, we_n} with cs_n low)
`define BANK_OPS       3'h0
`define AP_BIT         10
`define CMD_LOAD       3'h0
`define CMD_READ       3'h5
`define CMD_WRITE      3'h4
`define PIN_IDLE       20'hF0000
`endif

// >>> src/ddrms_pkg.sv
// Types of the operating-setting block
package ddrms_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LAT,
		ST_BURST,
		ST_RECOV
	} ddrms_state_t;
endpackage

// >>> src/ddrms_core.sv
// Operating setting, burst ordering and latency timing of the memory die
`timescale 1ns/1ps
`include "ddrms_map.svh"
module ddrms_core
	import ddrms_pkg::*;
(
	input  wire logic        clk,                  // 100 MHz clock
	input  wire logic        resetn,               // Async reset, low
	input  wire logic        cs_n,                 // Chip select, low
	input  wire logic        ras_n,                // Row strobe, low
	input  wire logic        cas_n,                // Column strobe, low
	input  wire logic        we_n,                 // Write enable, low
	input  wire logic [12:0] addr,                 // Address / fields
	input  wire logic [2:0]  bank,                 // Bank / register select
	input  wire logic [2:0]  posted_extra_latency, // Added read delay
	output logic [12:0]      operating_setting,    // Stored setting
	output logic             burst_count8,         // Burst of eight
	output logic             interleaved,          // Interleaved order
	output logic [2:0]       read_latency_setting, // Latency clocks
	output logic [3:0]       write_latency,        // Total write latency
	output logic             latency_reserved,     // Bad latency code
	output logic             test_mode,            // Test mode entered
	output logic             dll_reset_pulse,      // Loop reset strobe
	output logic             slow_exit_sel,        // Slow power-down exit
	output logic             read_data_phase,      // Read beat this clock
	output logic             write_data_phase,     // Write beat this clock
	output logic [9:0]       burst_col,            // Column of this beat
	output logic             internal_precharge    // Write auto precharge strobe
);
	// ============================================================
	// Pin synchroniser
	logic [19:0]  pin_meta_reg;
	logic [19:0]  pin_sync_reg;
	logic [2:0]   cmd;
	logic         cmd_load;
	logic         cmd_rw;
	logic [12:0]  a_s;
	logic [2:0]   ba_s;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta_reg <= `PIN_IDLE;
			pin_sync_reg <= `PIN_IDLE;
		end else begin
			pin_meta_reg <= {cs_n, ras_n, cas_n, we_n, bank, addr};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	assign cmd  = pin_sync_reg[18:16];
	assign ba_s = pin_sync_reg[15:13];
	assign a_s  = pin_sync_reg[12:0];
	assign cmd_load = !pin_sync_reg[19] && (cmd == `CMD_LOAD);
	assign cmd_rw   = !pin_sync_reg[19] &&
		((cmd == `CMD_READ) || (cmd == `CMD_WRITE));

	// ============================================================
	// Field decode
	function automatic logic [3:0] lat_sum(input logic [2:0] pe,
		input logic [2:0] rs);
		lat_sum = {1'b0, pe} + {1'b0, rs};
	endfunction

	// Column of beat n inside the aligned block
	function automatic logic [2:0] col_of(input logic [2:0] st,
		input logic [2:0] n, input logic bl8, input logic il);
		logic [1:0] low;
		low = il ? (st[1:0] ^ n[1:0]) : 2'(st[1:0] + n[1:0]);
		col_of = {bl8 ? (st[2] ^ n[2]) : st[2], low};
	endfunction

	logic [12:0] ops_reg;
	logic        tm_reg;
	logic [3:0]  rl_total;
	logic [3:0]  wr_clocks;

	assign operating_setting    = ops_reg;
	assign test_mode            = tm_reg;
	assign burst_count8 = (ops_reg[`OPS_BC_MSB:`OPS_BC_LSB] == `BC_CODE8);
	assign interleaved  = ops_reg[`OPS_BT_BIT];
	assign read_latency_setting = ops_reg[`OPS_RLS_MSB:`OPS_RLS_LSB];
	assign latency_reserved = (read_latency_setting < `RLS_CODE_MIN);
	assign slow_exit_sel    = ops_reg[`OPS_PDX_BIT];
	assign rl_total = lat_sum(posted_extra_latency, read_latency_setting);
	assign write_latency = 4'(rl_total - 4'h1);
	assign wr_clocks = 4'({1'b0, ops_reg[`OPS_WR_MSB:`OPS_WR_LSB]}
		+ `WR_CODE_OFFSET);

	// ============================================================
	// Setting register; loads touch only this register, never the array
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ops_reg <= `OPS_RESET;
			tm_reg  <= 1'b0;
		end else if (cmd_load && ba_s == `BANK_OPS) begin
			if (a_s[`OPS_TM_BIT]) begin
				tm_reg <= 1'b1;
			end else begin
				ops_reg <= a_s;
				tm_reg  <= 1'b0;
			end
		end else if (ops_reg[`OPS_DLL_BIT]) begin
			ops_reg[`OPS_DLL_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dll_reset_pulse <= 1'b0;
		end else begin
			dll_reset_pulse <= ops_reg[`OPS_DLL_BIT];
		end
	end

	a_dll_selfclear: assert property (@(posedge clk) disable iff (!resetn)
		ops_reg[`OPS_DLL_BIT] && !cmd_load
		|=> !ops_reg[`OPS_DLL_BIT] && dll_reset_pulse)
		else $error("loop reset bit did not clear with a pulse");
	a_hold_setting: assert property (@(posedge clk) disable iff (!resetn)
		!cmd_load |=> $stable(ops_reg[`OPS_PDX_BIT:`OPS_WR_LSB])
		&& $stable(ops_reg[`OPS_TM_BIT:0]))
		else $error("setting changed without a load");
	a_test_nostore: assert property (@(posedge clk) disable iff (!resetn)
		cmd_load && ba_s == `BANK_OPS && a_s[`OPS_TM_BIT]
		|=> tm_reg && $stable(ops_reg[`OPS_TM_BIT:0]))
		else $error("test mode load stored fields");
	a_bank_select: assert property (@(posedge clk) disable iff (!resetn)
		cmd_load && ba_s != `BANK_OPS && !ops_reg[`OPS_DLL_BIT]
		|=> $stable(ops_reg))
		else $error("other register load altered the setting");

	// ============================================================
	// Burst sequencer; one access is outstanding at a time, so a
	// command while busy is ignored (controller spacing assumed)
	ddrms_state_t state_reg;
	logic [3:0]   cnt_reg;
	logic [2:0]   beat_reg;
	logic [9:0]   start_reg;
	logic         wr_reg;
	logic         ap_reg;
	logic [2:0]   last_beat;

	assign last_beat = burst_count8 ? `LAST_BEAT8 : `LAST_BEAT4;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 4'h0;
			beat_reg  <= 3'h0;
			start_reg <= 10'h000;
			wr_reg    <= 1'b0;
			ap_reg    <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				if (cmd_rw) begin
					state_reg <= ST_LAT;
					start_reg <= a_s[9:0];
					wr_reg    <= (cmd == `CMD_WRITE);
					ap_reg    <= a_s[`AP_BIT];
					// Posted latency folds into the wait
					cnt_reg   <= (cmd == `CMD_WRITE) ?
						4'(write_latency - 4'h1) : 4'(rl_total - 4'h1);
				end
			end
			ST_LAT: begin
				if (cnt_reg == 4'h0) begin
					state_reg <= ST_BURST;
					beat_reg  <= 3'h0;
				end else begin
					cnt_reg <= 4'(cnt_reg - 4'h1);
				end
			end
			ST_BURST: begin
				beat_reg <= 3'(beat_reg + 3'h1);
				if (beat_reg == last_beat) begin
					if (wr_reg && ap_reg) begin
						state_reg <= ST_RECOV;
						cnt_reg   <= 4'(wr_clocks - 4'h2);
					end else begin
						state_reg <= ST_IDLE;
					end
				end
			end
			ST_RECOV: begin
				cnt_reg <= 4'(cnt_reg - 4'h1);
				if (cnt_reg == 4'h0) begin
					state_reg <= ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			internal_precharge <= 1'b0;
		end else begin
			internal_precharge <= (state_reg == ST_RECOV)
				&& (cnt_reg == 4'h0);
		end
	end

	// Block bits come from the start column; only the low bits walk
	assign burst_col = {start_reg[9:3],
		col_of(start_reg[2:0], beat_reg, burst_count8, interleaved)};
	assign read_data_phase  = (state_reg == ST_BURST) && !wr_reg;
	assign write_data_phase = (state_reg == ST_BURST) && wr_reg;

	// ============================================================
	// Checking helpers
	logic [3:0] since_reg;
	logic [3:0] exp_lat_reg;
	logic [3:0] since_last_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			since_reg      <= 4'h0;
			exp_lat_reg    <= 4'h0;
			since_last_reg <= 4'h0;
		end else begin
			// Zero at the taking edge, so it equals the edges since then
			if (state_reg == ST_IDLE && cmd_rw) begin
				since_reg   <= 4'h0;
				exp_lat_reg <= (cmd == `CMD_WRITE) ? write_latency : rl_total;
			end else begin
				since_reg <= 4'(since_reg + 4'h1);
			end
			if (state_reg == ST_BURST && beat_reg == last_beat) begin
				since_last_reg <= 4'h1;
			end else begin
				since_last_reg <= 4'(since_last_reg + 4'h1);
			end
		end
	end

	a_data_latency: assert property (@(posedge clk) disable iff (!resetn)
		$rose(state_reg == ST_BURST) |-> since_reg == exp_lat_reg)
		else $error("first beat not at command edge plus latency");
	a_write_early: assert property (@(posedge clk) disable iff (!resetn)
		$rose(write_data_phase) |-> exp_lat_reg == 4'(rl_total - 4'h1))
		else $error("write latency not read latency minus one");
	a_burst_eight: assert property (@(posedge clk) disable iff (!resetn)
		$rose(state_reg == ST_BURST) && burst_count8
		|-> (state_reg == ST_BURST)[*8] ##1 (state_reg != ST_BURST))
		else $error("burst of eight has wrong beat count");
	a_burst_four: assert property (@(posedge clk) disable iff (!resetn)
		$rose(state_reg == ST_BURST) && !burst_count8
		|-> (state_reg == ST_BURST)[*4] ##1 (state_reg != ST_BURST))
		else $error("burst of four has wrong beat count");
	a_block_wrap: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_BURST |-> burst_col[9:3] == start_reg[9:3]
		&& (burst_count8 || burst_col[2] == start_reg[2]))
		else $error("burst left its aligned block");
	a_order_type: assert property (@(posedge clk) disable iff (!resetn)
		state_reg == ST_BURST |-> burst_col[2:0] == (interleaved ?
		(start_reg[2:0] ^ beat_reg) : 3'(start_reg[2:0] + beat_reg))
		|| (!interleaved && burst_col[1:0] ==
		2'(start_reg[1:0] + beat_reg[1:0])))
		else $error("beat column out of order");
	a_recovery_gap: assert property (@(posedge clk) disable iff (!resetn)
		$rose(internal_precharge) |-> since_last_reg == wr_clocks)
		else $error("precharge not recovery clocks after last beat");
endmodule // ddrms_core

// >>> tb/ddrms_ctrl_model.sv
// Memory controller model driving the command and address pins
`timescale 1ns/1ps
`include "ddrms_map.svh"
module ddrms_ctrl_model (
	input  wire logic   clk,  // Device clock
	output logic        cs_n, // Chip select, low
	output logic        ras_n, // Row strobe, low
	output logic        cas_n, // Column strobe, low
	output logic        we_n, // Write enable, low
	output logic [12:0] addr, // Address / fields
	output logic [2:0]  bank  // Bank / register select
);
	// ========================================
	// Command driver
	initial {cs_n, ras_n, cas_n, we_n, addr, bank} = `PIN_IDLE;
	// Released address and bank lines show the inverse so a late sample is caught
	task automatic drive(input logic [2:0] cmd, input logic [2:0] ba,
		input logic [12:0] a);
		{cs_n, ras_n, cas_n, we_n} = {1'b0, cmd};
		bank = ba;
		addr = a;
		@(posedge clk);
		#1;
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		addr = ~a;
		bank = ~ba;
	endtask
	// All fields sent on each load; reserved upper bits do not exist here
	task automatic load(input logic [2:0] ba, input logic [12:0] v);
		drive(`CMD_LOAD, ba, v);
	endtask
endmodule // ddrms_ctrl_model

// >>> tb/ddr2_mode_setting_logic_tb.sv
// Self-checking bench of the operating-setting block
`timescale 1ns/1ps
`include "ddrms_map.svh"
module ddr2_mode_setting_logic_tb;
	import ddrms_pkg::*;
	// ========================================
	// Signals
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        cs_n, ras_n, cas_n, we_n;
	logic [12:0] addr, operating_setting;
	logic [2:0]  bank, read_latency_setting;
	logic [2:0]  posted_extra_latency = 3'h0;
	logic        burst_count8, interleaved, latency_reserved, test_mode;
	logic        dll_reset_pulse, slow_exit_sel, internal_precharge;
	logic        read_data_phase, write_data_phase;
	logic [3:0]  write_latency;
	logic [9:0]  burst_col;
	int          cyc = 0, dll_seen = 0, bad_count = 0, total_checks = 0;
	int          bq_cyc[$], pq[$];
	logic [9:0]  bq_col[$];
	logic        bq_wr[$];
	always #5 clk = ~clk;
	ddrms_ctrl_model m (.clk, .cs_n, .ras_n, .cas_n, .we_n, .addr, .bank);
	ddrms_core dut (.clk, .resetn, .cs_n, .ras_n, .cas_n, .we_n, .addr,
		.bank, .posted_extra_latency, .operating_setting, .burst_count8,
		.interleaved, .read_latency_setting, .write_latency,
		.latency_reserved, .test_mode, .dll_reset_pulse, .slow_exit_sel,
		.read_data_phase, .write_data_phase, .burst_col,
		.internal_precharge);
	// ========================================
	// Compare and verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ========================================
	// Monitor takes the oldest note per beat
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (read_data_phase === 1'b1 || write_data_phase === 1'b1) begin
			if (bq_col.size() == 0) check(16'h0, 16'h1);
			else begin
				check(16'(burst_col), 16'(bq_col.pop_front()));
				check(16'(cyc), 16'(bq_cyc.pop_front()));
				check(16'(write_data_phase), 16'(bq_wr.pop_front()));
			end
		end
		if (internal_precharge === 1'b1) begin
			if (pq.size() == 0) check(16'h0, 16'h2);
			else check(16'(cyc), 16'(pq.pop_front()));
		end
		if (dll_reset_pulse === 1'b1) dll_seen++;
	end
	// ========================================
	// Stimulus
	function automatic logic [9:0] beat(input logic [9:0] s, input int i,
		input logic b8, input logic il);
		logic [2:0] n;
		n = i[2:0];
		if (il) return b8 ? s ^ {7'h0, n} : s ^ {8'h0, n[1:0]};
		if (b8) return {s[9:3], s[2] ^ n[2], s[1:0] + n[1:0]};
		return {s[9:2], s[1:0] + n[1:0]};
	endfunction
	// Waits the load delay before any further command
	task automatic loadw(input logic [2:0] ba, input logic [12:0] v);
		@(posedge clk);
		#1;
		m.load(ba, v);
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic issue(input logic wr, input logic [9:0] s,
		input logic b8, input logic il, input int lat, input int wrc);
		int p;
		int nb;
		@(posedge clk);
		#1;
		p = cyc;
		nb = b8 ? 8 : 4;
		for (int i = 0; i < nb; i++) begin
			bq_col.push_back(beat(s, i, b8, il));
			bq_cyc.push_back(p + lat + 3 + i);
			bq_wr.push_back(wr);
		end
		// Precharge comes recovery clocks after the last beat's cycle
		if (wr) pq.push_back(p + lat + 2 + nb + wrc);
		m.drive(wr ? `CMD_WRITE : `CMD_READ, 3'h0, {2'h0, wr, s});
		// Next load only once the burst and recovery are over
		for (int k = 0; k < 60 && bq_col.size() + pq.size() > 0; k++)
			@(posedge clk);
		check(16'(bq_col.size() + pq.size()), 16'h0);
		repeat (3) @(posedge clk);
	endtask
	initial begin
		logic [12:0] v;
		int          lc, wr, pa;
		logic        b8, il;
		void'($urandom(73));
		repeat (2) @(posedge clk);
		#1;
		check(16'(operating_setting), 16'(`OPS_RESET));
		resetn = 1'b1;
		loadw(3'h0, 13'h0080);
		check(16'(test_mode), 16'h1);
		check(16'(operating_setting & 13'h1F7F), 16'(`OPS_RESET));
		loadw(3'h1, 13'h1FFF);
		check(16'(operating_setting & 13'h1F7F), 16'(`OPS_RESET));
		loadw(3'h0, 13'h0022);
		check(16'({test_mode, latency_reserved}), 16'h1);
		for (int c = 0; c < 8; c++) begin
			b8 = c[0];
			il = c[1];
			lc = 3 + $urandom_range(4);
			wr = 1 + $urandom_range(6);
			pa = $urandom_range(6);
			posted_extra_latency = pa[2:0];
			v = {c[2], wr[2:0], c == 0, 1'b0, lc[2:0], il,
				b8 ? `BC_CODE8 : `BC_CODE4};
			loadw(3'h0, v);
			check(16'(operating_setting), 16'(v & 13'h1EFF));
			check(16'({burst_count8, interleaved, slow_exit_sel}),
				16'({b8, il, c[2]}));
			check(16'({latency_reserved, read_latency_setting}),
				16'(lc));
			check(16'(write_latency), 16'(pa + lc - 1));
			if (c == 0) begin
				check(16'(dll_seen), 16'h1);
				repeat (200) @(posedge clk);
			end
			issue(1'b0, 10'($urandom_range(1023)), b8, il, pa + lc, 0);
			issue(1'b1, 10'($urandom_range(1023)), b8, il, pa + lc - 1,
				wr + 1);
		end
		test_done();
	end
	initial begin
		#100000;
		bad_count++;
		test_done();
	end
endmodule // ddr2_mode_setting_logic_tb
